// [hw/sfw_flash_cmd.v]
`include "sfw_flash_map.vh"
`default_nettype none
module sfw_flash_cmd #(
    parameter [31:0] PP_CYCLES = `SFW_PP_CYC,
    parameter [31:0] SE_CYCLES = `SFW_SE_CYC
) (
    // system
    input wire sys_clk,
    input wire rst,
    // link pins
    input wire cs_n_pin,
    input wire sclk_pin,
    input wire [3:0] io_in,
    output reg [3:0] io_out_q,
    output reg [3:0] io_oe_q,
    // configuration from status registers
    input wire quad_enable_bit,
    input wire four_line_command_mode,
    input wire protect_complement,
    input wire protect_granularity,
    input wire protect_top_bottom,
    input wire protect_level_hi,
    input wire protect_level_mid,
    input wire protect_level_lo,
    input wire [255:0] sector_lock_map,
    // status
    output reg busy_q,
    output reg write_enable_latch_q,
    output reg wrap_disable_bit_q,
    output reg [1:0] wrap_length_field_q,
    output reg [1:0] dummy_sel_q,
    // memory array
    output reg [23:0] mem_rd_addr_q,
    input wire [7:0] mem_rd_data,
    output reg mem_wr_en_q,
    output reg [23:0] mem_wr_addr_q,
    output reg [7:0] mem_wr_data_q,
    output reg mem_erase_q,
    output reg [23:0] mem_erase_addr_q
);
    // ------------------------------------------------------------
    // states and functions
    // ------------------------------------------------------------
    localparam [2:0] ST_OPC = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_DUMMY = 3'd2;
    localparam [2:0] ST_OUT = 3'd3;
    localparam [2:0] ST_DIN = 3'd4;
    localparam [2:0] ST_END = 3'd5;
    localparam [2:0] ST_PARAM = 3'd6;
    localparam [2:0] ST_IGN = 3'd7;
    localparam [1:0] OP_NONE = 2'd0;
    localparam [1:0] OP_PROG = 2'd1;
    localparam [1:0] OP_ERASE = 2'd2;

    // next read address, confined to an aligned section when wrapping
    function [23:0] next_addr;
        input [23:0] a;
        input wrap;
        input [1:0] len;
        reg [7:0] m;
        begin
            m = (8'h08 << len) - 8'h01;
            if (wrap)
                next_addr = {a[23:8], (a[7:0] & ~m) | ((a[7:0] + 8'h01) & m)};
            else
                next_addr = a + 24'h000001;
        end
    endfunction

    // block protection for a 1 MB array
    function is_protected;
        input [19:0] a;
        input cmp;
        input sec;
        input tb;
        input [2:0] lvl;
        reg [20:0] size;
        reg hit;
        begin
            size = 21'h0;
            if (lvl == 3'd0)
                hit = 1'b0;
            else if (!sec && lvl >= 3'd5)
                hit = 1'b1;
            else
            begin
                if (sec)
                    size = (lvl >= 3'd5) ? 21'h08000 : (21'h01000 << (lvl - 3'd1));
                else
                    size = 21'h10000 << (lvl - 3'd1);
                hit = tb ? ({1'b0, a} < size) : ({1'b0, a} >= (21'h100000 - size));
            end
            is_protected = hit ^ cmp;
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    reg [1:0] cs_s_q;
    reg [1:0] sclk_s_q;
    reg [3:0] io_s1_q;
    reg [3:0] io_s2_q;
    reg sclk_prev_q;
    reg cs_prev_q;

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cs_s_q <= 2'b11;
            sclk_s_q <= 2'b00;
            io_s1_q <= 4'h0;
            io_s2_q <= 4'h0;
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end
        else
        begin
            cs_s_q <= {cs_s_q[0], cs_n_pin};
            sclk_s_q <= {sclk_s_q[0], sclk_pin};
            io_s1_q <= io_in;
            io_s2_q <= io_s1_q;
            sclk_prev_q <= sclk_s_q[1];
            cs_prev_q <= cs_s_q[1];
        end
    end

    wire cs_hi = cs_s_q[1];
    wire cs_rise = cs_s_q[1] & ~cs_prev_q;
    wire sclk_rise = sclk_s_q[1] & ~sclk_prev_q & ~cs_hi;
    wire sclk_fall = ~sclk_s_q[1] & sclk_prev_q & ~cs_hi;

    // ------------------------------------------------------------
    // command engine
    // ------------------------------------------------------------
    reg [2:0] st_q;
    reg [7:0] cmd_q;
    reg [7:0] sr_q;
    reg [2:0] bcnt_q;
    reg [1:0] acnt_q;
    reg [23:0] addr_q;
    reg [3:0] dcnt_q;
    reg quad_q;
    reg wrap_rd_q;
    reg [7:0] obuf_q;
    reg [2:0] ocnt_q;
    reg any_data_q;
    reg rst_arm_q;
    reg [255:0] pvalid_q;
    reg [7:0] page_mem [0:255];
    reg [23:0] op_addr_q;
    reg [1:0] op_q;
    reg [31:0] tmr_q;
    reg scan_q;
    reg [7:0] scan_idx_q;

    wire [7:0] sr_next = quad_q ? {sr_q[3:0], io_s2_q} : {sr_q[6:0], io_s2_q[0]};
    wire [2:0] bcnt_next = bcnt_q + (quad_q ? 3'd4 : 3'd1);
    wire byte_done = (bcnt_next == 3'd0);
    wire [23:0] addr_full = {addr_q[15:0], sr_next};
    wire [7:0] stat_byte = {6'h00, write_enable_latch_q, busy_q};
    wire [2:0] prot_lvl = {protect_level_hi, protect_level_mid, protect_level_lo};
    wire op_prot = is_protected(op_addr_q[19:0], protect_complement, protect_granularity,
        protect_top_bottom, prot_lvl);
    wire op_lock = sector_lock_map[op_addr_q[19:12]];
    wire [7:0] out_cur = (ocnt_q != 3'd0) ? obuf_q : ((cmd_q == `SFW_OP_RDSR) ? stat_byte : mem_rd_data);
    wire [23:0] rd_next = next_addr(addr_q, wrap_rd_q, wrap_length_field_q);
    wire is_quad_read = (sr_next == `SFW_OP_QIO_READ) || (sr_next == `SFW_OP_WORD_QIO_READ);

    always @(posedge sys_clk)
    begin
        if (st_q == ST_DIN && sclk_rise && byte_done)
            page_mem[addr_q[7:0]] <= sr_next;
        mem_wr_data_q <= page_mem[scan_idx_q];
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= ST_OPC;
            cmd_q <= 8'h00;
            sr_q <= 8'h00;
            bcnt_q <= 3'd0;
            acnt_q <= 2'd0;
            addr_q <= 24'h000000;
            dcnt_q <= 4'h0;
            quad_q <= 1'b0;
            wrap_rd_q <= 1'b0;
            obuf_q <= 8'h00;
            ocnt_q <= 3'd0;
            any_data_q <= 1'b0;
            rst_arm_q <= 1'b0;
            pvalid_q <= 256'h0;
            op_addr_q <= 24'h000000;
            op_q <= OP_NONE;
            tmr_q <= 32'h00000000;
            scan_q <= 1'b0;
            scan_idx_q <= 8'h00;
            io_out_q <= 4'h0;
            io_oe_q <= 4'h0;
            busy_q <= 1'b0;
            write_enable_latch_q <= 1'b0;
            wrap_disable_bit_q <= `SFW_WRAP_DIS_RST;
            wrap_length_field_q <= `SFW_WRAP_LEN_RST;
            dummy_sel_q <= `SFW_DUMMY_SEL_RST;
            mem_rd_addr_q <= 24'h000000;
            mem_wr_en_q <= 1'b0;
            mem_wr_addr_q <= 24'h000000;
            mem_erase_q <= 1'b0;
            mem_erase_addr_q <= 24'h000000;
        end
        else
        begin
            mem_wr_en_q <= 1'b0;
            mem_erase_q <= 1'b0;
            // self-timed program and erase cycles
            if (busy_q)
            begin
                if (scan_q)
                begin
                    mem_wr_en_q <= pvalid_q[scan_idx_q];
                    mem_wr_addr_q <= {op_addr_q[23:8], scan_idx_q};
                    scan_idx_q <= scan_idx_q + 8'h01;
                    if (scan_idx_q == 8'hff)
                    begin
                        scan_q <= 1'b0;
                        op_q <= OP_NONE;
                    end
                end
                else if (tmr_q != 32'h00000000)
                    tmr_q <= tmr_q - 32'h00000001;
                else if (op_q == OP_PROG)
                begin
                    scan_q <= 1'b1;
                    scan_idx_q <= 8'h00;
                end
                else if (op_q == OP_ERASE)
                begin
                    mem_erase_q <= 1'b1;
                    mem_erase_addr_q <= {op_addr_q[23:12], 12'h000};
                    op_q <= OP_NONE;
                end
                else
                begin
                    // cycle ends one clock after its last array strobe
                    busy_q <= 1'b0;
                    write_enable_latch_q <= 1'b0;
                end
            end
            // frame end starts the cycle only on a byte boundary
            if (cs_rise && !busy_q && bcnt_q == 3'd0)
            begin
                if (st_q == ST_DIN && any_data_q && !op_prot)
                begin
                    busy_q <= 1'b1;
                    op_q <= OP_PROG;
                    tmr_q <= PP_CYCLES - 32'h00000001;
                end
                else if (st_q == ST_END && !op_prot && !op_lock)
                begin
                    busy_q <= 1'b1;
                    op_q <= OP_ERASE;
                    tmr_q <= SE_CYCLES - 32'h00000001;
                end
            end
            if (cs_hi)
            begin
                st_q <= ST_OPC;
                bcnt_q <= 3'd0;
                ocnt_q <= 3'd0;
                quad_q <= four_line_command_mode;
                io_oe_q <= 4'h0;
            end
            else if (sclk_rise && st_q == ST_DUMMY)
            begin
                dcnt_q <= dcnt_q - 4'h1;
                if (dcnt_q == 4'h1)
                    st_q <= ST_OUT;
            end
            else if (sclk_rise && st_q == ST_END)
                st_q <= ST_IGN;
            else if (sclk_rise && st_q != ST_OUT && st_q != ST_IGN)
            begin
                sr_q <= sr_next;
                bcnt_q <= bcnt_next;
                if (byte_done)
                begin
                    case (st_q)
                        ST_OPC:
                        begin
                            cmd_q <= sr_next;
                            acnt_q <= 2'd0;
                            rst_arm_q <= (sr_next == `SFW_OP_RST_ARM);
                            st_q <= ST_IGN;
                            if (sr_next == `SFW_OP_RDSR)
                                st_q <= ST_OUT;
                            else if (busy_q)
                                st_q <= ST_IGN;
                            else if (sr_next == `SFW_OP_WREN)
                                write_enable_latch_q <= 1'b1;
                            else if (sr_next == `SFW_OP_WRDI)
                                write_enable_latch_q <= 1'b0;
                            else if (sr_next == `SFW_OP_RST_GO && rst_arm_q)
                            begin
                                dummy_sel_q <= `SFW_DUMMY_SEL_RST;
                                write_enable_latch_q <= 1'b0;
                            end
                            else if (sr_next == `SFW_OP_SET_PARAM && four_line_command_mode)
                                st_q <= ST_PARAM;
                            else if (sr_next == `SFW_OP_SET_WRAP)
                            begin
                                st_q <= ST_ADDR;
                                quad_q <= 1'b1;
                            end
                            else if (is_quad_read && quad_enable_bit)
                            begin
                                st_q <= ST_ADDR;
                                quad_q <= 1'b1;
                                wrap_rd_q <= !four_line_command_mode && !wrap_disable_bit_q;
                            end
                            else if (sr_next == `SFW_OP_WRAP_READ && four_line_command_mode)
                            begin
                                st_q <= ST_ADDR;
                                wrap_rd_q <= 1'b1;
                            end
                            else if (write_enable_latch_q && (sr_next == `SFW_OP_PROG
                                || sr_next == `SFW_OP_SECT_ERASE))
                                st_q <= ST_ADDR;
                            else if (write_enable_latch_q && quad_enable_bit
                                && sr_next == `SFW_OP_QPROG)
                            begin
                                st_q <= ST_ADDR;
                                quad_q <= 1'b1;
                            end
                        end
                        ST_ADDR:
                        begin
                            addr_q <= addr_full;
                            acnt_q <= acnt_q + 2'd1;
                            if (acnt_q == 2'd2)
                            begin
                                op_addr_q <= addr_full;
                                mem_rd_addr_q <= addr_full;
                                any_data_q <= 1'b0;
                                pvalid_q <= 256'h0;
                                if (cmd_q == `SFW_OP_SET_WRAP)
                                    st_q <= ST_PARAM;
                                else if (cmd_q == `SFW_OP_PROG || cmd_q == `SFW_OP_QPROG)
                                    st_q <= ST_DIN;
                                else if (cmd_q == `SFW_OP_SECT_ERASE)
                                    st_q <= ST_END;
                                else
                                begin
                                    st_q <= ST_DUMMY;
                                    if (four_line_command_mode)
                                        dcnt_q <= {1'b0, dummy_sel_q, 1'b0} + 4'h2;
                                    else if (cmd_q == `SFW_OP_WORD_QIO_READ)
                                        dcnt_q <= `SFW_SPI_WORD_DUMMY;
                                    else
                                        dcnt_q <= `SFW_SPI_QIO_DUMMY;
                                end
                            end
                        end
                        ST_DIN:
                        begin
                            pvalid_q[addr_q[7:0]] <= 1'b1;
                            any_data_q <= 1'b1;
                            addr_q <= {addr_q[23:8], addr_q[7:0] + 8'h01};
                        end
                        ST_PARAM:
                        begin
                            st_q <= ST_IGN;
                            if (cmd_q == `SFW_OP_SET_WRAP)
                            begin
                                wrap_disable_bit_q <= sr_next[`SFW_WRAP_DIS_BIT];
                                wrap_length_field_q <= sr_next[`SFW_WRAP_LEN_HI:`SFW_WRAP_LEN_LO];
                            end
                            else
                            begin
                                dummy_sel_q <= sr_next[`SFW_PARAM_DUMMY_HI:`SFW_PARAM_DUMMY_LO];
                                wrap_length_field_q <= sr_next[1:0];
                            end
                        end
                        default:
                            st_q <= ST_IGN;
                    endcase
                end
            end
            else if (sclk_fall && st_q == ST_OUT)
            begin
                if (quad_q)
                begin
                    io_out_q <= out_cur[7:4];
                    io_oe_q <= 4'hf;
                    obuf_q <= {out_cur[3:0], 4'h0};
                    ocnt_q <= ocnt_q + 3'd4;
                end
                else
                begin
                    io_out_q <= {2'b00, out_cur[7], 1'b0};
                    io_oe_q <= 4'h2;
                    obuf_q <= {out_cur[6:0], 1'b0};
                    ocnt_q <= ocnt_q + 3'd1;
                end
                if (ocnt_q == 3'd0 && cmd_q != `SFW_OP_RDSR)
                begin
                    addr_q <= rd_next;
                    mem_rd_addr_q <= rd_next;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [inc/sfw_flash_map.vh]
// Notes on behaviour
// - wrapped quad reads stay in aligned section
// - wrapped read restarts at section start
// - four-line read dummy clocks 2/4/6/8, default 2
// - no wrap on four-line quad read; use 0ch
// - 77h, 24 dummy bits, 8 wrap bits
// - wrap disable bit and length field decode
// - wrap setting kept for later quad reads
// - wrap disabled after power-on
// - wrap length survives mode change; param command sets it
// - page program 02h needs write enable latch
// - program address wraps within 256-byte page
// - select rise off byte boundary discards program or erase
// - self-timed program cycle with busy set
// - program completion clears write enable latch
// - protected pages are never programmed
// - quad page program 32h needs quad enable
// - sector erase 20h erases 4k sector
// - erase timed, skipped when protected or locked
// - quad read needs quad enable bit
// - reads other than status 05h ignored during busy cycles
`ifndef SFW_FLASH_MAP_VH
`define SFW_FLASH_MAP_VH
// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define SFW_OP_WREN 8'h06
`define SFW_OP_WRDI 8'h04
`define SFW_OP_RDSR 8'h05
`define SFW_OP_QIO_READ 8'heb
`define SFW_OP_WORD_QIO_READ 8'he7
`define SFW_OP_WRAP_READ 8'h0c
`define SFW_OP_SET_WRAP 8'h77
`define SFW_OP_SET_PARAM 8'hc0
`define SFW_OP_PROG 8'h02
`define SFW_OP_QPROG 8'h32
`define SFW_OP_SECT_ERASE 8'h20
`define SFW_OP_RST_ARM 8'h66
`define SFW_OP_RST_GO 8'h99
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define SFW_WRAP_DIS_BIT 4
`define SFW_WRAP_LEN_HI 6
`define SFW_WRAP_LEN_LO 5
`define SFW_PARAM_DUMMY_HI 5
`define SFW_PARAM_DUMMY_LO 4
`define SFW_WRAP_DIS_RST 1'b1
`define SFW_WRAP_LEN_RST 2'h0
`define SFW_DUMMY_SEL_RST 2'h0
`define SFW_SPI_QIO_DUMMY 4'h6
`define SFW_SPI_WORD_DUMMY 4'h4
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SFW_CLK_NS 5
`define SFW_T_PP_NS 400000
`define SFW_T_SE_NS 30000000
`define SFW_PP_CYC ((`SFW_T_PP_NS + `SFW_CLK_NS - 1) / `SFW_CLK_NS)
`define SFW_SE_CYC ((`SFW_T_SE_NS + `SFW_CLK_NS - 1) / `SFW_CLK_NS)
`endif

// [verif/sfw_flash_cmd_sva.sv]
`default_nettype none
module sfw_flash_cmd_sva #(
    parameter [31:0] PP_CYCLES = 32'h7d0,
    parameter [31:0] SE_CYCLES = 32'hbb8
) (
    // system
    input wire logic sys_clk,
    input wire logic rst,
    // link and config
    input wire logic cs_n_pin,
    input wire logic [3:0] io_oe_q,
    input wire logic four_line_command_mode,
    // status and array
    input wire logic busy_q,
    input wire logic write_enable_latch_q,
    input wire logic [1:0] dummy_sel_q,
    input wire logic mem_wr_en_q,
    input wire logic mem_erase_q,
    input wire logic [23:0] mem_erase_addr_q
);
    logic [31:0] busy_cnt_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // length of the current busy stretch
    always_ff @(posedge sys_clk or posedge rst)
        if (rst)
            busy_cnt_q <= 32'h0;
        else
            busy_cnt_q <= busy_q ? busy_cnt_q + 32'h1 : 32'h0;

    oe_release_a: assert property (cs_n_pin [*5] |-> io_oe_q == 4'h0)
        else $error("data pins driven while deselected");
    write_busy_a: assert property (mem_wr_en_q |-> busy_q)
        else $error("array write outside a program cycle");
    erase_align_a: assert property (mem_erase_q |-> mem_erase_addr_q[11:0] == 12'h000)
        else $error("erase address not sector aligned");
    erase_end_a: assert property (mem_erase_q |-> ##[0:2] !busy_q && !write_enable_latch_q)
        else $error("erase did not finish after the erase pulse");
    wel_clear_a: assert property ($fell(busy_q) |-> !write_enable_latch_q)
        else $error("write enable latch kept after cycle end");
    busy_start_a: assert property ($rose(busy_q) |-> cs_n_pin && $past(write_enable_latch_q))
        else $error("cycle started without latch or while selected");
    busy_time_a: assert property ($fell(busy_q) |-> busy_cnt_q >= PP_CYCLES)
        else $error("busy cycle shorter than the program time");
    wel_idle_a: assert property ($rose(write_enable_latch_q) |-> !busy_q)
        else $error("write enable accepted while busy");
    dummy_mode_a: assert property ($changed(dummy_sel_q) |-> four_line_command_mode || dummy_sel_q == 2'h0)
        else $error("dummy select changed outside four-line mode");
endmodule

bind sfw_flash_cmd sfw_flash_cmd_sva #(.PP_CYCLES(PP_CYCLES), .SE_CYCLES(SE_CYCLES)) sva_i (
    .sys_clk, .rst, .cs_n_pin, .io_oe_q, .four_line_command_mode, .busy_q, .write_enable_latch_q,
    .dummy_sel_q, .mem_wr_en_q, .mem_erase_q, .mem_erase_addr_q);
`default_nettype wire

// [verif/sfw_host.sv]
`default_nettype none
module sfw_host (
    // link pins
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io_w,
    // device data pins
    input wire logic [3:0] dev_o,
    input wire logic [3:0] dev_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] drv = 4'h0;
    logic [3:0] oe_h = 4'h0;
    logic [3:0] got;

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
    end

    // a lane driven by neither side shows the inverse of its last level
    always_comb
        for (int i = 0; i < 4; i++)
            io_w[i] = oe_h[i] ? drv[i] : dev_oe[i] ? dev_o[i] : ~drv[i];

    // one mode 0 clock: data set while low, sampled on the rise
    task automatic tick(input logic [3:0] d, input logic [3:0] oe);
        drv = (d & oe) | (drv & ~oe);
        oe_h = oe;
        #24 sclk = 1'b1;
        got = dev_o;
        #24 sclk = 1'b0;
    endtask

    task automatic open_f;
        cs_n = 1'b0;
    endtask

    task automatic close_f;
        oe_h = 4'h0;
        #24 cs_n = 1'b1;
        #96;
    endtask

    task automatic put(input logic [7:0] b, input logic quad);
        if (quad)
        begin
            tick(b[7:4], 4'hf);
            tick(b[3:0], 4'hf);
        end
        else
            for (int i = 7; i >= 0; i--)
                tick({3'h0, b[i]}, 4'h1);
    endtask

    task automatic get(output logic [7:0] b, input logic quad);
        for (int i = 7; i >= 0; i = i - (quad ? 4 : 1))
        begin
            tick(4'h0, 4'h0);
            if (quad)
                b[i -: 4] = got;
            else
                b[i] = got[1];
        end
    endtask
endmodule
`default_nettype wire

// [verif/sfw_flash_cmd_tb.sv]
`include "sfw_flash_map.vh"
`default_nettype none
module sfw_flash_cmd_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, cs_n, sclk, qe, fl, busy, write_enable_latch, wdis, wr_en, er_en;
    logic [3:0] io_w, io_out, io_oe;
    logic [5:0] prot;
    logic [255:0] lock;
    logic [1:0] wlen, dsel;
    logic [23:0] rd_a, wr_a, er_a;
    logic [7:0] wr_d, b;
    logic [7:0] wmem [int];
    logic [23:0] eq [$];
    int fails, cmp_count;

    sfw_flash_cmd #(.PP_CYCLES(32'h7d0), .SE_CYCLES(32'hbb8)) dut (
        .sys_clk(sys_clk), .rst(rst), .cs_n_pin(cs_n), .sclk_pin(sclk), .io_in(io_w), .io_out_q(io_out),
        .io_oe_q(io_oe), .quad_enable_bit(qe), .four_line_command_mode(fl), .protect_complement(prot[5]),
        .protect_granularity(prot[4]), .protect_top_bottom(prot[3]), .protect_level_hi(prot[2]),
        .protect_level_mid(prot[1]), .protect_level_lo(prot[0]), .sector_lock_map(lock), .busy_q(busy),
        .write_enable_latch_q(write_enable_latch), .wrap_disable_bit_q(wdis), .wrap_length_field_q(wlen), .dummy_sel_q(dsel),
        .mem_rd_addr_q(rd_a), .mem_rd_data(rd_a[7:0]), .mem_wr_en_q(wr_en), .mem_wr_addr_q(wr_a),
        .mem_wr_data_q(wr_d), .mem_erase_q(er_en), .mem_erase_addr_q(er_a));

    sfw_host host (.cs_n(cs_n), .sclk(sclk), .io_w(io_w), .dev_o(io_out), .dev_oe(io_oe));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // array model: reads return the low address byte
    always @(posedge sys_clk)
    begin
        if (wr_en === 1'b1)
            wmem[wr_a] = wr_d;
        if (er_en === 1'b1)
            eq.push_back(er_a);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 8000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (busy !== 1'b0)
        begin
            fails++;
            summarize();
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic q);
        host.open_f();
        host.put(op, fl);
        for (int i = 2; i >= 0; i--)
            host.put(a[i*8 +: 8], q);
    endtask

    task automatic one(input logic [7:0] op, input logic q);
        host.open_f();
        host.put(op, q);
        host.close_f();
    endtask

    initial
    begin
        rst = 1'b1;
        {qe, fl, prot, lock, fails, cmp_count} = '0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk({busy, write_enable_latch, wdis, wlen, dsel}, 32'h10);
        cmd(`SFW_OP_PROG, 24'h000010, 1'b0);
        host.put(8'h55, 1'b0);
        host.close_f();
        chk(busy, 32'h0);
        $display("test reset and refusal done");
        one(`SFW_OP_WREN, 1'b0);
        cmd(`SFW_OP_PROG, 24'h0000fe, 1'b0);
        for (int i = 1; i < 4; i++)
            host.put(8'h11 * i, 1'b0);
        host.close_f();
        chk(busy, 32'h1);
        host.open_f();
        host.put(`SFW_OP_RDSR, 1'b0);
        host.get(b, 1'b0);
        host.close_f();
        chk(b, 32'h3);
        cmd(`SFW_OP_PROG, 24'h000080, 1'b0);
        host.put(8'h77, 1'b0);
        host.close_f();
        wait_idle();
        chk(write_enable_latch, 32'h0);
        chk(wmem.num(), 32'h3);
        chk({wmem[24'hfe], wmem[24'hff], wmem[24'h0]}, 32'h112233);
        $display("test page program done");
        one(`SFW_OP_WREN, 1'b0);
        cmd(`SFW_OP_PROG, 24'h000040, 1'b0);
        host.put(8'h99, 1'b0);
        host.tick(4'h1, 4'h1);
        host.close_f();
        chk(busy, 32'h0);
        cmd(`SFW_OP_SECT_ERASE, 24'h012345, 1'b0);
        host.close_f();
        chk(busy, 32'h1);
        wait_idle();
        chk(eq.size(), 32'h1);
        chk(eq[0], 32'h12000);
        chk(write_enable_latch, 32'h0);
        lock[8'h23] = 1'b1;
        one(`SFW_OP_WREN, 1'b0);
        cmd(`SFW_OP_SECT_ERASE, 24'h023000, 1'b0);
        host.close_f();
        chk(busy, 32'h0);
        lock = '0;
        prot = 6'h01;
        cmd(`SFW_OP_PROG, 24'h0ff000, 1'b0);
        host.put(8'h5a, 1'b0);
        host.close_f();
        chk(busy, 32'h0);
        prot = 6'h00;
        $display("test erase and protection done");
        for (int k = 0; k < 2; k++)
        begin
            qe = k[0];
            cmd(`SFW_OP_QPROG, 24'h000100, 1'b1);
            host.put(8'haa, 1'b1);
            host.close_f();
            chk(busy, k);
        end
        wait_idle();
        chk(wmem[24'h100], 32'haa);
        $display("test quad program done");
        host.open_f();
        host.put(`SFW_OP_SET_WRAP, 1'b0);
        for (int i = 0; i < 4; i++)
            host.put(i == 3 ? 8'hcf : 8'h00, 1'b1);
        host.close_f();
        chk({wdis, wlen}, 32'h2);
        cmd(`SFW_OP_QIO_READ, 24'h00003c, 1'b1);
        host.put(8'h00, 1'b1);
        repeat (4) host.tick(4'h0, 4'h0);
        for (int i = 0; i < 8; i++)
        begin
            host.get(b, 1'b1);
            chk(b, 8'h20 | ((8'h1c + i) & 8'h1f));
        end
        host.close_f();
        cmd(`SFW_OP_SET_WRAP, 24'h000000, 1'b1);
        host.put(8'h10, 1'b1);
        host.close_f();
        chk(wdis, 32'h1);
        $display("test wrapped read done");
        fl = 1'b1;
        host.open_f();
        host.put(`SFW_OP_SET_PARAM, 1'b1);
        host.put(8'h31, 1'b1);
        host.close_f();
        chk({dsel, wlen}, 32'hd);
        for (int k = 0; k < 2; k++)
        begin
            cmd(k ? `SFW_OP_QIO_READ : `SFW_OP_WRAP_READ, 24'h00001e, 1'b1);
            repeat (8) host.tick(4'h0, 4'h0);
            for (int i = 0; i < 4; i++)
            begin
                host.get(b, 1'b1);
                chk(b, k ? 8'h1e + i : 8'h10 | ((8'h0e + i) & 8'h0f));
            end
            host.close_f();
        end
        one(`SFW_OP_RST_ARM, 1'b1);
        one(`SFW_OP_RST_GO, 1'b1);
        chk(dsel, 32'h0);
        $display("test four-line parameters done");
        summarize();
    end
endmodule
`default_nettype wire
